// [inc/fafc_pkg.sv]
// constants for the fifo alert and framing control block
//
// Function
// R1: the warning threshold is six bits wide in the low bits, bits 7:6 read zero, reset value 8.
// R2: nearly-full is high while free fifo space is at or below the threshold.
// R3: nearly-empty is high while the fifo byte count is at or below the threshold.
// R4: writing one to control bit 7 stops the timer at once.
// R5: writing one to control bit 6 starts the timer at once.
// R6: both timer strobe bits always read back as zero.
// R7: writing one to the copy bit pushes the 10 identifier bytes into the fifo, then the bit clears.
// R8: control bit 4 selects initiator when one and target when zero.
// R9: a read-only three-bit field gives the valid bits of the last received byte, zero meaning all.
// R10: writing one to framing bit 7 starts transmission, only while transceive is running.
// R11: the receive alignment field sets where the first received bit lands in the first byte.
// R12: with alignment 7 the first bit goes to bit 7 and the second to bit 0 of the next byte.
// R13: software keeps the alignment at zero outside bitwise anticollision at 106 kbit/s.
// R14: the three-bit transmit last-bits field sets bits sent of the last byte, 000 meaning eight.
// R15: the monitored fifo holds 64 bytes, so free space is 64 minus the count.
// R16: during transceive the transmitter waits in state 001 until the kick is written.
// R17: both fifo flags are recomputed every cycle from the current count and threshold.
package fafc_pkg;
  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_THR = 6'h0b;
  localparam logic [5:0] IDX_CTRL = 6'h0c;
  localparam logic [5:0] IDX_FRAME = 6'h0d;
  localparam logic [5:0] IDX_IRQ_STAT = 6'h10;
  localparam logic [5:0] IDX_IRQ_CLR = 6'h11;
  localparam logic [5:0] IDX_IRQ_EN = 6'h12;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_STOP_BIT = 7;
  localparam int CTRL_START_BIT = 6;
  localparam int CTRL_COPY_BIT = 5;
  localparam int CTRL_ROLE_BIT = 4;
  localparam int FRAME_KICK_BIT = 7;
  localparam int FRAME_ALIGN_LSB = 4;
  localparam int THR_W = 6;
  localparam logic [5:0] THR_RST = 6'h08;
  localparam logic [2:0] FIELD3_RST = 3'h0;
  localparam int IRQ_W = 4;
  localparam int IRQ_FULL = 0;
  localparam int IRQ_EMPTY = 1;
  localparam int IRQ_COPY = 2;
  localparam int IRQ_RX = 3;
  // ----------------------------------------------------------------
  // sizes and transmitter state codes
  // ----------------------------------------------------------------
  localparam int FIFO_DEPTH_DEF = 64;
  localparam int ID_BYTES_DEF = 10;
  localparam logic [2:0] MS_IDLE = 3'h0;
  localparam logic [2:0] MS_WAIT_KICK = 3'h1;
  localparam logic [2:0] MS_SENDING = 3'h3;
  typedef enum logic [1:0] {TX_IDLE, TX_WAIT_KICK, TX_SENDING, TX_HOLD} fafc_tx_st_t;
endpackage

// [logic/fafc_id_copy.sv]
// pushes the stored identifier into the fifo one byte per cycle
`timescale 1ns/10ps
`default_nettype none
module fafc_id_copy
  import fafc_pkg::*;
#(
  parameter int ID_BYTES = ID_BYTES_DEF
)
(
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic start_i,
  input wire logic [ID_BYTES*8-1:0] id_i,
  output logic busy_o,
  output logic done_o,
  // fifo write side
  output logic push_o,
  output logic [7:0] data_o
);
  if (ID_BYTES < 1 || ID_BYTES > 15)
  begin : g_chk
    $error("fafc_id_copy: ID_BYTES out of range");
  end

  logic [3:0] cnt_r;
  logic [4:0] run_r;
  wire last_w = (cnt_r == 4'(ID_BYTES - 1));

  // byte counter, low byte first
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      busy_o <= 1'b0;
      cnt_r <= 4'h0;
      push_o <= 1'b0;
      data_o <= 8'h00;
      done_o <= 1'b0;
    end
    else
    begin
      push_o <= busy_o;
      data_o <= busy_o ? id_i[cnt_r*8 +: 8] : 8'h00; // no index past the last byte
      done_o <= busy_o && last_w;
      if (start_i && !busy_o)
      begin
        busy_o <= 1'b1;
        cnt_r <= 4'h0;
      end
      else if (busy_o)
      begin
        busy_o <= !last_w;
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end

  // length of the current run of pushes, helper for the check below
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      run_r <= 5'h00;
    else
      run_r <= push_o ? run_r + 5'h01 : 5'h00;
  end

  // every run of pushes is exactly one identifier long
  a_copy_count: assert property (@(posedge clk_i) disable iff (rst_i) // R7
    $fell(push_o) |-> run_r == 5'(ID_BYTES))
    else $error("identifier copy did not push exactly one identifier");

  // pushing begins two cycles after the start
  a_copy_start: assert property (@(posedge clk_i) disable iff (rst_i) // R7
    start_i && !busy_o |=> ##1 push_o)
    else $error("identifier copy did not start pushing");
endmodule
`default_nettype wire

// [logic/fafc_rx_align.sv]
// packs received bits into bytes starting at the chosen bit position
`timescale 1ns/10ps
`default_nettype none
module fafc_rx_align
  import fafc_pkg::*;
(
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // bit stream from the receiver
  input wire logic frame_start_i,
  input wire logic bit_valid_i,
  input wire logic bit_i,
  input wire logic frame_end_i,
  input wire logic [2:0] align_i,
  // packed bytes
  output logic push_o,
  output logic [7:0] data_o,
  output logic [2:0] last_bits_o,
  output logic done_o
);
  logic [2:0] pos_r;
  logic [7:0] byte_r;

  // state after taking this cycle's bit
  wire [7:0] byte_a = bit_valid_i ? (byte_r | (8'(bit_i) << pos_r)) : byte_r;
  wire [2:0] pos_a = bit_valid_i ? pos_r + 3'h1 : pos_r;
  wire wrap_w = bit_valid_i && (pos_r == 3'h7);
  wire part_w = frame_end_i && (pos_a != 3'h0);

  // byte assembly
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pos_r <= 3'h0;
      byte_r <= 8'h00;
      push_o <= 1'b0;
      data_o <= 8'h00;
      last_bits_o <= FIELD3_RST;
      done_o <= 1'b0;
    end
    else
    begin
      push_o <= wrap_w || part_w; // R12
      data_o <= byte_a;
      done_o <= frame_end_i;
      if (frame_end_i)
        last_bits_o <= pos_a; // R9
      if (frame_start_i)
      begin
        pos_r <= align_i; // R11
        byte_r <= 8'h00;
      end
      else if (wrap_w || frame_end_i)
      begin
        pos_r <= 3'h0;
        byte_r <= 8'h00;
      end
      else
      begin
        pos_r <= pos_a;
        byte_r <= byte_a;
      end
    end
  end

  // alignment 7: the first bit alone fills the first byte
  a_align_wrap: assert property (@(posedge clk_i) disable iff (rst_i) // R12
    frame_start_i && align_i == 3'h7 ##1 bit_valid_i && !frame_start_i
    |=> push_o && data_o[7] == $past(bit_i) && data_o[6:0] == 7'h00)
    else $error("alignment seven did not close the first byte");
endmodule
`default_nettype wire

// [logic/fafc_top.sv]
// fifo alert, timer strobes, identifier copy and bit framing registers
//
// Chosen here: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module fafc_top
  import fafc_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF,
  parameter int ID_BYTES = ID_BYTES_DEF
)
(
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  // fifo monitor
  input wire logic [6:0] fifo_level_i,
  output logic fifo_nearly_full_flag_o,
  output logic fifo_nearly_empty_flag_o,
  // timer
  output logic timer_start_strobe_o,
  output logic timer_stop_strobe_o,
  // identifier copy into the fifo
  input wire logic [ID_BYTES*8-1:0] stored_peer_identifier_i,
  output logic id_push_o,
  output logic [7:0] id_data_o,
  // role and transmitter
  output logic initiator_o,
  input wire logic transceive_active_i,
  input wire logic tx_done_i,
  output logic transmit_kick_o,
  output logic [2:0] modem_state_o,
  output logic [2:0] tx_bits_last_byte_o,
  // receiver bit stream
  input wire logic rx_frame_start_i,
  input wire logic rx_bit_valid_i,
  input wire logic rx_bit_i,
  input wire logic rx_frame_end_i,
  output logic rx_push_o,
  output logic [7:0] rx_data_o
);
  if (FIFO_DEPTH < 2 || FIFO_DEPTH > 127)
  begin : g_chk
    $error("fafc_top: FIFO_DEPTH out of range");
  end

  // ------------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------------
  logic [5:0] thr_r;
  logic [2:0] rx_align_r;
  logic [IRQ_W-1:0] irq_status_r;
  logic [IRQ_W-1:0] irq_en_r;
  logic full_r;
  logic empty_r;
  fafc_tx_st_t tx_st_r;
  fafc_tx_st_t tx_st_nxt;
  wire copy_busy_w;
  wire copy_done_w;
  wire rx_done_w;
  wire [2:0] rx_last_w;

  // register index match
  function automatic logic hit(input logic [7:0] adr, input logic [5:0] idx);
    hit = (adr[7:2] == idx);
  endfunction

  wire acc_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr_w = acc_w && wb_we_i && wb_sel_i[0];
  wire [7:0] wd_w = wb_dat_i[7:0];
  wire hit_thr_w = hit(wb_adr_i, IDX_THR);
  wire hit_ctrl_w = hit(wb_adr_i, IDX_CTRL);
  wire hit_frame_w = hit(wb_adr_i, IDX_FRAME);
  wire hit_stat_w = hit(wb_adr_i, IDX_IRQ_STAT);
  wire hit_clr_w = hit(wb_adr_i, IDX_IRQ_CLR);
  wire hit_en_w = hit(wb_adr_i, IDX_IRQ_EN);
  wire wr_ctrl_w = wr_w && hit_ctrl_w;
  wire wr_frame_w = wr_w && hit_frame_w;

  // ------------------------------------------------------------------
  // control decode
  // ------------------------------------------------------------------
  wire stop_w = wr_ctrl_w && wd_w[CTRL_STOP_BIT];
  wire start_w = wr_ctrl_w && wd_w[CTRL_START_BIT];
  wire copy_go_w = wr_ctrl_w && wd_w[CTRL_COPY_BIT];
  wire kick_ok_w = wr_frame_w && wd_w[FRAME_KICK_BIT] && transceive_active_i
    && (tx_st_r == TX_WAIT_KICK);

  // fifo flag comparison against the current count
  wire [6:0] free_w = 7'(FIFO_DEPTH) - fifo_level_i; // R15
  wire full_nxt_w = (free_w <= {1'b0, thr_r}); // R2 R17
  wire empty_nxt_w = (fifo_level_i <= {1'b0, thr_r}); // R3 R17

  // read data selection; strobes and clear register read zero
  wire [7:0] rd_ctrl_w = {2'b00, copy_busy_w, initiator_o, 1'b0, rx_last_w}; // R6 R7
  wire [7:0] rd_frame_w = {1'b0, rx_align_r, 1'b0, tx_bits_last_byte_o};
  wire [7:0] rd_w = hit_thr_w ? {2'b00, thr_r} :
    hit_ctrl_w ? rd_ctrl_w :
    hit_frame_w ? rd_frame_w :
    hit_stat_w ? {4'h0, irq_status_r} :
    hit_en_w ? {4'h0, irq_en_r} : 8'h00;

  // interrupt events; a set in the clearing cycle wins
  wire [IRQ_W-1:0] ev_w = {rx_done_w, copy_done_w, empty_nxt_w && !empty_r,
    full_nxt_w && !full_r};
  wire [IRQ_W-1:0] clr_w = (wr_w && hit_clr_w) ? wd_w[IRQ_W-1:0] : 4'h0;
  wire [IRQ_W-1:0] stat_nxt_w = (irq_status_r & ~clr_w) | ev_w;
  wire [IRQ_W-1:0] en_nxt_w = (wr_w && hit_en_w) ? wd_w[IRQ_W-1:0] : irq_en_r;

  // transmitter state code
  function automatic logic [2:0] ms_code(input fafc_tx_st_t st);
    case (st)
      TX_WAIT_KICK: ms_code = MS_WAIT_KICK;
      TX_SENDING: ms_code = MS_SENDING;
      default: ms_code = MS_IDLE;
    endcase
  endfunction

  // ------------------------------------------------------------------
  // transmitter sequencing
  // ------------------------------------------------------------------
  always_comb
  begin
    tx_st_nxt = tx_st_r;
    case (tx_st_r)
      TX_IDLE:
        if (transceive_active_i)
          tx_st_nxt = TX_WAIT_KICK;
      TX_WAIT_KICK:
        if (!transceive_active_i)
          tx_st_nxt = TX_IDLE;
        else if (kick_ok_w)
          tx_st_nxt = TX_SENDING; // R16
      TX_SENDING:
        if (tx_done_i || !transceive_active_i)
          tx_st_nxt = TX_HOLD;
      TX_HOLD:
        if (!transceive_active_i)
          tx_st_nxt = TX_IDLE;
      default:
        tx_st_nxt = TX_IDLE;
    endcase
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  // bus answer, registered ack one cycle after the strobe
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= acc_w;
      if (acc_w)
        wb_dat_o <= {24'h00_0000, rd_w};
    end
  end

  // software written fields
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      thr_r <= THR_RST;
      initiator_o <= 1'b0;
      rx_align_r <= FIELD3_RST;
      tx_bits_last_byte_o <= FIELD3_RST;
    end
    else
    begin
      if (wr_w && hit_thr_w)
        thr_r <= wd_w[THR_W-1:0]; // R1
      if (wr_ctrl_w)
        initiator_o <= wd_w[CTRL_ROLE_BIT]; // R8
      if (wr_frame_w)
      begin
        rx_align_r <= wd_w[FRAME_ALIGN_LSB +: 3]; // R11
        tx_bits_last_byte_o <= wd_w[2:0]; // R14
      end
    end
  end

  // strobes, flags, interrupt, transmitter state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      timer_stop_strobe_o <= 1'b0;
      timer_start_strobe_o <= 1'b0;
      transmit_kick_o <= 1'b0;
      full_r <= 1'b0;
      empty_r <= 1'b0;
      irq_status_r <= 4'h0;
      irq_en_r <= 4'h0;
      irq_o <= 1'b0;
      tx_st_r <= TX_IDLE;
      modem_state_o <= MS_IDLE;
    end
    else
    begin
      timer_stop_strobe_o <= stop_w; // R4
      timer_start_strobe_o <= start_w; // R5
      transmit_kick_o <= kick_ok_w; // R10
      full_r <= full_nxt_w; // R2
      empty_r <= empty_nxt_w; // R3
      irq_status_r <= stat_nxt_w;
      irq_en_r <= en_nxt_w;
      irq_o <= |(stat_nxt_w & en_nxt_w);
      tx_st_r <= tx_st_nxt;
      modem_state_o <= ms_code(tx_st_nxt); // R16
    end
  end

  assign fifo_nearly_full_flag_o = full_r;
  assign fifo_nearly_empty_flag_o = empty_r;

  // ------------------------------------------------------------------
  // submodules
  // ------------------------------------------------------------------
  fafc_id_copy #(
    .ID_BYTES(ID_BYTES)
  ) u_copy (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(copy_go_w), // R7
    .id_i(stored_peer_identifier_i),
    .busy_o(copy_busy_w),
    .done_o(copy_done_w),
    .push_o(id_push_o),
    .data_o(id_data_o)
  );

  fafc_rx_align u_rx (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .frame_start_i(rx_frame_start_i),
    .bit_valid_i(rx_bit_valid_i),
    .bit_i(rx_bit_i),
    .frame_end_i(rx_frame_end_i),
    .align_i(rx_align_r),
    .push_o(rx_push_o),
    .data_o(rx_data_o),
    .last_bits_o(rx_last_w),
    .done_o(rx_done_w)
  );

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  a_thr_reset: assert property (@(posedge clk_i) // R1
    rst_i |=> thr_r == 6'h08 && wb_dat_o == 32'h0000_0000)
    else $error("threshold not eight after reset");

  a_full_flag: assert property (@(posedge clk_i) disable iff (rst_i) // R2 R15 R17
    !$past(rst_i) |-> fifo_nearly_full_flag_o ==
      ((7'd64 - $past(fifo_level_i)) <= {1'b0, $past(thr_r)}))
    else $error("nearly full flag wrong");

  a_empty_flag: assert property (@(posedge clk_i) disable iff (rst_i) // R3 R17
    !$past(rst_i) |-> fifo_nearly_empty_flag_o ==
      ($past(fifo_level_i) <= {1'b0, $past(thr_r)}))
    else $error("nearly empty flag wrong");

  a_stop_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // R4
    wr_ctrl_w && wb_dat_i[7] |=> timer_stop_strobe_o ##1 !timer_stop_strobe_o)
    else $error("timer stop strobe not a single pulse");

  a_start_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // R5
    wr_ctrl_w && wb_dat_i[6] |=> timer_start_strobe_o ##1 !timer_start_strobe_o)
    else $error("timer start strobe not a single pulse");

  a_strobe_readzero: assert property (@(posedge clk_i) disable iff (rst_i) // R6
    acc_w && !wb_we_i && hit_ctrl_w |=> wb_ack_o && wb_dat_o[7:6] == 2'b00)
    else $error("timer strobe bits read nonzero");

  a_kick_gated: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    transmit_kick_o |-> $past(transceive_active_i) && modem_state_o == 3'h3)
    else $error("kick without transceive");

  a_wait_kick: assert property (@(posedge clk_i) disable iff (rst_i) // R16
    modem_state_o == 3'h1 && transceive_active_i && !kick_ok_w |=> modem_state_o == 3'h1)
    else $error("left wait state without kick");

  a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o == |(irq_status_r & irq_en_r))
    else $error("interrupt level wrong");
endmodule
`default_nettype wire

// [sim/fafc_top_tb_top.sv]
// self-checking testbench for the fifo alert and framing control block
`timescale 1ns/10ps
`default_nettype none
module fafc_top_tb_top
  import fafc_pkg::*;
;
  typedef struct {logic [7:0] adr; logic [7:0] wd; logic [7:0] exp;} fafc_row_t;
  // ------------------------------
  // stimulus and observed signals
  // ------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] sel = 4'h1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [6:0] level = 7'h00;
  logic active = 1'b0;
  logic tx_done = 1'b0;
  logic [3:0] rx = 4'h0;
  logic [31:0] dat_o;
  logic ack, irq, nfull, nempty, t_start, t_stop, id_push, initiator, kick, rx_push;
  logic [7:0] id_data, rx_data;
  logic [2:0] mstate, txlast;
  logic [7:0] idq[$];
  logic [7:0] rxq[$];
  int n_errors = 0;
  int checks_done = 0;
  int n_start = 0;
  int n_stop = 0;
  int n_kick = 0;
  int n_cyc = 0;
  // register rows: address, written value, value read back
  fafc_row_t rows [8] = '{'{8'h2c, 8'hff, 8'h3f}, '{8'h2c, 8'h05, 8'h05},
    '{8'h30, 8'hd0, 8'h10}, '{8'h34, 8'hff, 8'h77}, '{8'h34, 8'h03, 8'h03},
    '{8'h3c, 8'hff, 8'h00}, '{8'h44, 8'hff, 8'h00}, '{8'h48, 8'h0f, 8'h0f}};

  fafc_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .irq_o(irq), .fifo_level_i(level), .fifo_nearly_full_flag_o(nfull),
    .fifo_nearly_empty_flag_o(nempty), .timer_start_strobe_o(t_start),
    .timer_stop_strobe_o(t_stop), .stored_peer_identifier_i(80'h1a19_1817_1615_1413_1211),
    .id_push_o(id_push), .id_data_o(id_data), .initiator_o(initiator),
    .transceive_active_i(active), .tx_done_i(tx_done), .transmit_kick_o(kick),
    .modem_state_o(mstate), .tx_bits_last_byte_o(txlast), .rx_frame_start_i(rx[3]),
    .rx_bit_valid_i(rx[2]), .rx_bit_i(rx[1]), .rx_frame_end_i(rx[0]),
    .rx_push_o(rx_push), .rx_data_o(rx_data));

  // clock and hang guard
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    n_cyc++;
    if (n_cyc == 20000)
    begin
      n_errors++;
      end_of_test();
    end
  end
  // count strobes and collect pushed bytes
  always @(posedge clk_i)
  begin
    if (t_start === 1'b1) n_start++;
    if (t_stop === 1'b1) n_stop++;
    if (kick === 1'b1) n_kick++;
    if (id_push === 1'b1) idq.push_back(id_data);
    if (rx_push === 1'b1) rxq.push_back(rx_data);
  end
  // ------------------------------
  // tasks
  // ------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // one classic bus cycle, entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] r);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h00_0000, d};
    do
    begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    chk(ack, 1);
    r = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] r;
    bus(1'b0, a, 8'h00, r);
    chk(r, e);
  endtask
  task automatic rx_step(input logic [3:0] v);
    rx <= v;
    @(posedge clk_i);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ------------------------------
  // main sequence
  // ------------------------------
  initial
  begin
    wait_clk(4);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd_chk(8'h2c, 8'h08);
    rd_chk(8'h30, 8'h00);
    rd_chk(8'h34, 8'h00);
    $display("test reset done");
    foreach (rows[i])
    begin
      wr(rows[i].adr, rows[i].wd);
      rd_chk(rows[i].adr, rows[i].exp);
    end
    chk(initiator, 1);
    chk(txlast, 3);
    chk(n_start, 1);
    chk(n_stop, 1);
    chk(n_kick, 0);
    $display("test registers done");
    // sweep the fifo count against threshold 5
    wr(8'h48, 8'h00);
    for (int l = 0; l <= FIFO_DEPTH_DEF; l++)
    begin
      level <= 7'(l);
      wait_clk(2);
      chk(nfull, (FIFO_DEPTH_DEF - l) <= 5);
      chk(nempty, l <= 5);
    end
    rd_chk(8'h40, 8'h01);
    wr(8'h48, 8'h01);
    wait_clk(2);
    chk(irq, 1);
    wr(8'h44, 8'h01);
    wait_clk(2);
    chk(irq, 0);
    level <= 7'h00;
    wait_clk(2);
    rd_chk(8'h40, 8'h02);
    wr(8'h44, 8'h02);
    // a write without byte lane 0 leaves the threshold alone
    sel <= 4'h0;
    wr(8'h2c, 8'h3f);
    sel <= 4'h1;
    rd_chk(8'h2c, 8'h05);
    $display("test flags done");
    // identifier copy, busy bit then ten bytes
    wr(8'h30, 8'h20);
    rd_chk(8'h30, 8'h20);
    wait_clk(16);
    rd_chk(8'h30, 8'h00);
    chk(idq.size(), ID_BYTES_DEF);
    foreach (idq[i]) chk(idq[i], 8'h11 + i);
    rd_chk(8'h40, 8'h04);
    wr(8'h44, 8'h04);
    $display("test copy done");
    // kick ignored outside transceive and while sending
    wr(8'h34, 8'h80);
    chk(n_kick, 0);
    chk(mstate, MS_IDLE);
    active <= 1'b1;
    wait_clk(3);
    chk(mstate, MS_WAIT_KICK);
    wr(8'h34, 8'h80);
    chk(n_kick, 1);
    chk(mstate, MS_SENDING);
    wr(8'h34, 8'h80);
    chk(n_kick, 1);
    tx_done <= 1'b1;
    @(posedge clk_i);
    tx_done <= 1'b0;
    wait_clk(2);
    chk(mstate, MS_IDLE);
    active <= 1'b0;
    $display("test kick done");
    // alignment 7: one bit fills a byte, the rest wrap to bit 0
    wr(8'h48, 8'h00);
    wr(8'h34, 8'h70);
    rx_step(4'h8);
    rx_step(4'h6);
    rx_step(4'h4);
    rx_step(4'h6);
    rx_step(4'h1);
    rx_step(4'h0);
    wait_clk(3);
    chk(rxq.size(), 2);
    chk(rxq[0], 8'h80);
    chk(rxq[1], 8'h02);
    rd_chk(8'h30, 8'h02);
    chk(irq, 0);
    wr(8'h48, 8'h08);
    wait_clk(2);
    chk(irq, 1);
    wr(8'h44, 8'h08);
    wait_clk(2);
    chk(irq, 0);
    // alignment 3: five ones complete a whole byte
    wr(8'h34, 8'h30);
    rx_step(4'h8);
    repeat (5) rx_step(4'h6);
    rx_step(4'h1);
    rx_step(4'h0);
    wait_clk(3);
    chk(rxq.size(), 3);
    chk(rxq[2], 8'hf8);
    rd_chk(8'h30, 8'h00);
    wr(8'h34, 8'h05);
    rd_chk(8'h34, 8'h05);
    $display("test receive done");
    // reset in mid-run brings the registers back
    rst_i <= 1'b1;
    wait_clk(4);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd_chk(8'h2c, 8'h08);
    rd_chk(8'h34, 8'h00);
    chk(mstate, MS_IDLE);
    $display("test mid reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
